// ### core/vdc_pkg.sv
// constants, types and small decoders shared by the video decoder config block
// assumes a single 100 MHz clock domain; no timescale needed here
package vdc_pkg;

    // serial control port slave address (arbitrary value)
    localparam logic [6:0] VDC_DEV_ADDR      = 7'h21;
    localparam logic [3:0] VDC_BYTE_BITS     = 4'h8;

    // register offsets
    localparam logic [7:0] VDC_OFS_PAL_COMB  = 8'h39;
    localparam logic [7:0] VDC_OFS_SEL_PWR   = 8'h3a;
    localparam logic [7:0] VDC_OFS_KILL      = 8'h3d;
    localparam logic [7:0] VDC_OFS_RESAMPLE  = 8'h41;
    localparam logic [7:0] VDC_OFS_CHROMA    = 8'h4d;
    localparam logic [7:0] VDC_OFS_EDGE_TH   = 8'h4e;
    localparam logic [7:0] VDC_OFS_NOISE_TH  = 8'h50;

    // field positions
    localparam int VDC_TAPS_LSB   = 6;
    localparam int VDC_OVR_BIT    = 0;
    localparam int VDC_PDN_C_BIT  = 1;
    localparam int VDC_PDN_B_BIT  = 2;
    localparam int VDC_PDN_A_BIT  = 3;
    localparam int VDC_KILL_LSB   = 4;
    localparam int VDC_PSW_BIT    = 6;
    localparam int VDC_CTI_BIT    = 0;
    localparam int VDC_BLEND_BIT  = 1;
    localparam int VDC_BLVL_LSB   = 2;
    localparam int VDC_DNR_BIT    = 5;

    // reserved bits read back at their fixed default pattern
    localparam logic [7:0] VDC_SEL_PWR_FIX   = 8'h00;
    localparam logic [7:0] VDC_KILL_FIX      = 8'h02;
    localparam logic [7:0] VDC_RESAMPLE_FIX  = 8'h01;
    localparam logic [7:0] VDC_CHROMA_FIX    = 8'hc0;

    // values after reset
    localparam logic [1:0] VDC_TAPS_RST      = 2'h3;
    localparam logic [2:0] VDC_COMB_SEL_RST  = 3'h4;
    localparam logic [3:0] VDC_SEL_PWR_RST   = 4'h0;
    localparam logic [2:0] VDC_KILL_THR_RST  = 3'h0;
    localparam logic [1:0] VDC_BLVL_RST      = 2'h0;
    localparam logic [7:0] VDC_EDGE_TH_RST   = 8'h08;
    localparam logic [7:0] VDC_NOISE_TH_RST  = 8'h08;

    localparam logic [1:0] VDC_TAPS_UNUSED   = 2'h0;
    localparam logic [2:0] VDC_KILL_RSVD     = 3'h7;

    // kill levels in tenths of a percent, indexed by threshold code
    localparam logic [8:0] VDC_KILL_NP [0:7] = '{9'h005, 9'h00f, 9'h019, 9'h028,
                                                 9'h055, 9'h0a0, 9'h140, 9'h000};
    localparam logic [8:0] VDC_KILL_SC [0:7] = '{9'h000, 9'h032, 9'h046, 9'h050,
                                                 9'h05f, 9'h096, 9'h140, 9'h000};

    // input select ranges: cvbs, y/c, component, differential
    localparam logic [4:0] VDC_INPUT_SELECT_FIELD_YC      = 5'h08;
    localparam logic [4:0] VDC_INPUT_SELECT_FIELD_COMP    = 5'h0e;
    localparam logic [4:0] VDC_INPUT_SELECT_FIELD_DIFF    = 5'h10;

    // selectors in use for a given input select code, bit 2 = c, 1 = b, 0 = a
    function automatic logic [2:0] vdc_used_sel(input logic [4:0] sel);
        if (sel < VDC_INPUT_SELECT_FIELD_YC)
            return 3'h1;
        else if (sel < VDC_INPUT_SELECT_FIELD_COMP)
            return 3'h3;
        else if (sel < VDC_INPUT_SELECT_FIELD_DIFF)
            return 3'h7;
        else
            return 3'h3;
    endfunction : vdc_used_sel

    typedef enum logic [7:0] {
        VDC_IDLE  = 8'h01,
        VDC_ADDR  = 8'h02,
        VDC_ACKA  = 8'h04,
        VDC_SUB   = 8'h08,
        VDC_ACKW  = 8'h10,
        VDC_WDATA = 8'h20,
        VDC_RDATA = 8'h40,
        VDC_RACK  = 8'h80
    } vdc_i2c_state_t;

    typedef struct packed {
        logic [1:0]     sclSy;
        logic [1:0]     sdaSy;
        logic           sclP;
        logic           sdaP;
        vdc_i2c_state_t state;
        logic [3:0]     cnt;
        logic [7:0]     sh;
        logic           rw;
        logic [7:0]     ptr;
        logic           sdaOe;
        logic           wrStb;
        logic [7:0]     wrAddr;
        logic [7:0]     wrData;
    } vdc_i2c_t;

    typedef struct packed {
        logic [1:0] taps;
        logic [3:0] selPwr;
        logic [2:0] killThr;
        logic       palSwInv;
        logic       ctiEn;
        logic       blendEn;
        logic [1:0] blendLvl;
        logic       dnrEn;
        logic [7:0] edgeTh;
        logic [7:0] noiseTh;
        logic [2:0] combSel;
        logic [2:0] selPdn;
        logic       killOn;
        logic       secamKillOn;
        logic [8:0] killNp;
        logic [8:0] killSc;
        logic       palSw;
    } vdc_regs_t;

endpackage : vdc_pkg

// ### core/vdc_i2c_slave.sv
// two-wire serial control port slave with sub-address pointer and auto-increment
// assumes scl/sda arrive asynchronously and the register bank answers rdData combinationally
`timescale 1ns/10ps
`default_nettype none
module vdc_i2c_slave
    import vdc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOe,
    output logic            wrStb,
    output logic [7:0]      wrAddr,
    output logic [7:0]      wrData,
    output logic [7:0]      rdAddr,
    input  wire logic [7:0] rdData
);

    vdc_i2c_t st_r;
    vdc_i2c_t st_nxt;
    logic     sclQ;
    logic     sdaQ;
    logic     rise;
    logic     fall;

    // only the second synchroniser stage feeds edge and condition detection
    assign sclQ = st_r.sclSy[1];
    assign sdaQ = st_r.sdaSy[1];
    assign rise = sclQ & ~st_r.sclP;
    assign fall = ~sclQ & st_r.sclP;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.sclSy = {st_r.sclSy[0], scl};
        st_nxt.sdaSy = {st_r.sdaSy[0], sdaIn};
        st_nxt.sclP  = sclQ;
        st_nxt.sdaP  = sdaQ;
        st_nxt.wrStb = 1'b0;
        if (sclQ && st_r.sclP && st_r.sdaP && !sdaQ)
        begin
            st_nxt.state = VDC_ADDR;
            st_nxt.cnt   = 4'h0;
            st_nxt.sdaOe = 1'b0;
        end
        else if (sclQ && st_r.sclP && !st_r.sdaP && sdaQ)
        begin
            st_nxt.state = VDC_IDLE;
            st_nxt.sdaOe = 1'b0;
        end
        else
        begin
            unique case (st_r.state)
                VDC_IDLE: ;
                VDC_ADDR, VDC_SUB, VDC_WDATA:
                begin
                    if (rise)
                    begin
                        st_nxt.sh  = {st_r.sh[6:0], sdaQ};
                        st_nxt.cnt = st_r.cnt + 4'h1;
                    end
                    else if (fall && st_r.cnt == VDC_BYTE_BITS)
                    begin
                        st_nxt.cnt   = 4'h0;
                        st_nxt.sdaOe = 1'b1;
                        st_nxt.state = VDC_ACKW;
                        if (st_r.state == VDC_ADDR)
                        begin
                            st_nxt.rw = st_r.sh[0];
                            st_nxt.state = VDC_ACKA;
                            // another address: stay off the bus until the next start
                            if (st_r.sh[7:1] != VDC_DEV_ADDR)
                            begin
                                st_nxt.sdaOe = 1'b0;
                                st_nxt.state = VDC_IDLE;
                            end
                        end
                        else if (st_r.state == VDC_SUB)
                            st_nxt.ptr = st_r.sh;
                        else
                        begin
                            st_nxt.wrStb  = 1'b1;
                            st_nxt.wrAddr = st_r.ptr;
                            st_nxt.wrData = st_r.sh;
                            st_nxt.ptr    = st_r.ptr + 8'h01;
                        end
                    end
                end
                VDC_ACKA:
                    if (fall && st_r.rw)
                    begin
                        st_nxt.sh    = {rdData[6:0], 1'b0};
                        st_nxt.sdaOe = ~rdData[7];
                        st_nxt.state = VDC_RDATA;
                    end
                    else if (fall)
                    begin
                        st_nxt.sdaOe = 1'b0;
                        st_nxt.state = VDC_SUB;
                    end
                VDC_ACKW:
                    if (fall)
                    begin
                        st_nxt.sdaOe = 1'b0;
                        st_nxt.state = VDC_WDATA;
                    end
                VDC_RDATA:
                    if (rise)
                        st_nxt.cnt = st_r.cnt + 4'h1;
                    else if (fall && st_r.cnt == VDC_BYTE_BITS)
                    begin
                        st_nxt.cnt   = 4'h0;
                        st_nxt.sdaOe = 1'b0;
                        st_nxt.ptr   = st_r.ptr + 8'h01;
                        st_nxt.state = VDC_RACK;
                    end
                    else if (fall)
                    begin
                        st_nxt.sdaOe = ~st_r.sh[7];
                        st_nxt.sh    = {st_r.sh[6:0], 1'b0};
                    end
                VDC_RACK:
                    if (rise && sdaQ)
                        st_nxt.state = VDC_IDLE;
                    else if (fall)
                    begin
                        st_nxt.sh    = {rdData[6:0], 1'b0};
                        st_nxt.sdaOe = ~rdData[7];
                        st_nxt.state = VDC_RDATA;
                    end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st_r <= '{sclSy: 2'h3, sdaSy: 2'h3, sclP: 1'b1, sdaP: 1'b1,
                      state: VDC_IDLE, default: '0};
        else
            st_r <= st_nxt;
    end

    assign sdaOe  = st_r.sdaOe;
    assign wrStb  = st_r.wrStb;
    assign wrAddr = st_r.wrAddr;
    assign wrData = st_r.wrData;
    assign rdAddr = st_r.ptr;

endmodule : vdc_i2c_slave
`default_nettype wire

// ### core/vdc_config_regs.sv
// video decoder configuration register bank reached over the two-wire control port
// assumes inputSelect, colorKillEnable and palSwitchRaw come from logic on sys_clk
//
// Notes on behaviour
// - the pal chroma comb tap code picks 5-to-3 two-tap, 5-to-3 three-tap or 5-to-4, and 00 is never taken.
// - with the override bit clear the per-selector power-down bits have no effect.
// - with the override set, selectors not used by the chosen input select code are powered down.
// - bit 1 powers down the third selector with its clamp and buffer when the override is set.
// - bit 2 powers down the second selector with its clamp and buffer when the override is set.
// - bit 3 powers down the first selector with its clamp and buffer when the override is set.
// - the three-bit threshold picks the ntsc/pal and secam kill levels, with code 111 reserved.
// - the threshold acts only while color kill is enabled, otherwise no kill at all.
// - bit 6 of the resample register sets the polarity of the pal switch bit in the lock output.
// - bit 0 enables the chroma transient improver and bit 1 enables the blend with original chroma.
// - bits 3:2 choose the blend from sharpest (00) to smoothest (11).
// - bit 5 enables the noise reduction stages, clear bypasses them.
// - the byte at 0x4e is the least chroma edge the improver steepens, reset 0x08.
// - the byte at 0x50 is the amplitude below which variation is removed as noise, reset 0x08.
`timescale 1ns/10ps
`default_nettype none
module vdc_config_regs
    import vdc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [4:0] inputSelect,
    input  wire logic       colorKillEnable,
    input  wire logic       palSwitchRaw,
    output logic [2:0]      palCombSel,
    output logic [2:0]      selectorPowerdown,
    output logic            colorKillActive,
    output logic            secamKillActive,
    output logic [8:0]      killLevelNtscPal,
    output logic [8:0]      killLevelSecam,
    output logic            subcarrierPalSwitch,
    output logic            chromaImproverEnable,
    output logic            chromaBlendEnable,
    output logic [1:0]      chromaBlendLevel,
    output logic            noiseReductionEnable,
    output logic [7:0]      chromaEdgeThreshold,
    output logic [7:0]      noiseThreshold
);

    vdc_regs_t  st_r;
    vdc_regs_t  st_nxt;
    logic       wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic [2:0] manualPdn;

    vdc_i2c_slave u_port (
        .sys_clk (sys_clk),
        .rst     (rst),
        .scl     (scl),
        .sdaIn   (sdaIn),
        .sdaOe   (sdaOe),
        .wrStb   (wrStb),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .rdAddr  (rdAddr),
        .rdData  (rdData)
    );

    // open drain: the pin is only ever pulled low
    assign sdaOut = 1'b0;

    assign manualPdn = {st_r.selPwr[VDC_PDN_C_BIT], st_r.selPwr[VDC_PDN_B_BIT],
                        st_r.selPwr[VDC_PDN_A_BIT]};

    // readback; reserved bits show their fixed pattern, unmapped offsets read zero
    always_comb
    begin
        rdData = 8'h00;
        unique case (rdAddr)
            VDC_OFS_PAL_COMB: rdData = {st_r.taps, 6'h00};
            VDC_OFS_SEL_PWR:  rdData = VDC_SEL_PWR_FIX | {4'h0, st_r.selPwr};
            VDC_OFS_KILL:     rdData = VDC_KILL_FIX | {1'b0, st_r.killThr, 4'h0};
            VDC_OFS_RESAMPLE: rdData = VDC_RESAMPLE_FIX | {1'b0, st_r.palSwInv, 6'h00};
            VDC_OFS_CHROMA:   rdData = VDC_CHROMA_FIX | {2'h0, st_r.dnrEn, 1'b0,
                                                         st_r.blendLvl, st_r.blendEn, st_r.ctiEn};
            VDC_OFS_EDGE_TH:  rdData = st_r.edgeTh;
            VDC_OFS_NOISE_TH: rdData = st_r.noiseTh;
            default:          rdData = 8'h00;
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        // writes to reserved bits are dropped so they keep their defaults
        if (wrStb)
        begin
            unique case (wrAddr)
                VDC_OFS_PAL_COMB:
                    // the unused tap code is refused, the previous choice stands
                    if (wrData[VDC_TAPS_LSB +: 2] != VDC_TAPS_UNUSED)
                        st_nxt.taps = wrData[VDC_TAPS_LSB +: 2];
                VDC_OFS_SEL_PWR:  st_nxt.selPwr = wrData[3:0];
                VDC_OFS_KILL:     st_nxt.killThr = wrData[VDC_KILL_LSB +: 3];
                VDC_OFS_RESAMPLE: st_nxt.palSwInv = wrData[VDC_PSW_BIT];
                VDC_OFS_CHROMA:
                begin
                    st_nxt.ctiEn    = wrData[VDC_CTI_BIT];
                    st_nxt.blendEn  = wrData[VDC_BLEND_BIT];
                    st_nxt.blendLvl = wrData[VDC_BLVL_LSB +: 2];
                    st_nxt.dnrEn    = wrData[VDC_DNR_BIT];
                end
                VDC_OFS_EDGE_TH:  st_nxt.edgeTh = wrData;
                VDC_OFS_NOISE_TH: st_nxt.noiseTh = wrData;
                default: ;
            endcase
        end

        unique case (st_r.taps)
            2'h1:    st_nxt.combSel = 3'h1;
            2'h2:    st_nxt.combSel = 3'h2;
            2'h3:    st_nxt.combSel = 3'h4;
            default: st_nxt.combSel = st_r.combSel;
        endcase

        // auto power-down follows inputSelect through one register, so a new input wakes its channels one edge later
        if (st_r.selPwr[VDC_OVR_BIT])
            st_nxt.selPdn = manualPdn | ~vdc_used_sel(inputSelect);
        else
            st_nxt.selPdn = 3'h0;

        // reserved threshold code is treated as no kill
        st_nxt.killOn      = colorKillEnable && st_r.killThr != VDC_KILL_RSVD;
        st_nxt.killNp      = st_nxt.killOn ? VDC_KILL_NP[st_r.killThr] : 9'h000;
        st_nxt.killSc      = st_nxt.killOn ? VDC_KILL_SC[st_r.killThr] : 9'h000;
        st_nxt.secamKillOn = st_nxt.killOn && VDC_KILL_SC[st_r.killThr] != 9'h000;

        st_nxt.palSw = palSwitchRaw ^ st_r.palSwInv;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st_r <= '{taps: VDC_TAPS_RST, selPwr: VDC_SEL_PWR_RST, killThr: VDC_KILL_THR_RST,
                      blendLvl: VDC_BLVL_RST, edgeTh: VDC_EDGE_TH_RST,
                      noiseTh: VDC_NOISE_TH_RST, combSel: VDC_COMB_SEL_RST, default: '0};
        else
            st_r <= st_nxt;
    end

    assign palCombSel           = st_r.combSel;
    assign selectorPowerdown    = st_r.selPdn;
    assign colorKillActive      = st_r.killOn;
    assign secamKillActive      = st_r.secamKillOn;
    assign killLevelNtscPal     = st_r.killNp;
    assign killLevelSecam       = st_r.killSc;
    assign subcarrierPalSwitch  = st_r.palSw;
    assign chromaImproverEnable = st_r.ctiEn;
    assign chromaBlendEnable    = st_r.blendEn;
    assign chromaBlendLevel     = st_r.blendLvl;
    assign noiseReductionEnable = st_r.dnrEn;
    assign chromaEdgeThreshold  = st_r.edgeTh;
    assign noiseThreshold       = st_r.noiseTh;

    // checks
    logic [2:0] unusedSel;
    assign unusedSel = ~vdc_used_sel(inputSelect);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // a field lands one edge after the strobe; the comb selection and kill outputs one edge later
    sequence tapsWr(logic [1:0] code);
        wrStb && wrAddr == VDC_OFS_PAL_COMB && wrData[7:6] == code;
    endsequence

    sequence regWr(logic [7:0] ofs);
        wrStb && wrAddr == ofs;
    endsequence

    sequence killSet(logic [2:0] code);
        colorKillEnable && st_r.killThr == code;
    endsequence

    // comb tap decode; 00 must leave the previous choice in place
    taps_two_a: assert property (
        tapsWr(2'h1)
        |-> ##2 palCombSel == 3'h1)
        else $error("tap code 01 did not select 5-to-3 two tap");

    taps_decode_a: assert property (
        tapsWr(2'h2)
        |-> ##2 palCombSel == 3'h2)
        else $error("tap code 10 did not select 5-to-3 three tap");

    taps_four_a: assert property (
        tapsWr(2'h3)
        |-> ##2 palCombSel == 3'h4)
        else $error("tap code 11 did not select 5-to-4");

    taps_unused_a: assert property (
        tapsWr(2'h0)
        |=> $stable(st_r.taps) ##1 $stable(palCombSel))
        else $error("unused tap code changed comb selection");

    // selector power-down follows inputSelect one edge late
    override_off_a: assert property (
        !st_r.selPwr[VDC_OVR_BIT]
        |=> selectorPowerdown == 3'h0)
        else $error("selector powered down without override");

    auto_pdn_a: assert property (
        st_r.selPwr[VDC_OVR_BIT]
        |=> (selectorPowerdown & $past(unusedSel)) == $past(unusedSel))
        else $error("unused selector left powered");

    cvbs_pdn_a: assert property (
        st_r.selPwr[VDC_OVR_BIT] && inputSelect < VDC_INPUT_SELECT_FIELD_YC
        |=> selectorPowerdown[2:1] == 2'h3)
        else $error("selectors unused by a composite input left powered");

    selc_pdn_a: assert property (
        st_r.selPwr[VDC_OVR_BIT] && st_r.selPwr[VDC_PDN_C_BIT]
        |=> selectorPowerdown[2])
        else $error("third selector not powered down");

    selb_pdn_a: assert property (
        st_r.selPwr[VDC_OVR_BIT] && st_r.selPwr[VDC_PDN_B_BIT]
        |=> selectorPowerdown[1])
        else $error("second selector not powered down");

    sela_pdn_a: assert property (
        st_r.selPwr[VDC_OVR_BIT] && st_r.selPwr[VDC_PDN_A_BIT]
        |=> selectorPowerdown[0])
        else $error("first selector not powered down");

    // color kill; code 111 is reserved and treated as no kill
    kill_level_a: assert property (
        killSet(3'h4)
        |=> killLevelNtscPal == 9'h055 && killLevelSecam == 9'h05f)
        else $error("wrong kill levels for code 100");

    secam_none_a: assert property (
        killSet(3'h0)
        |=> colorKillActive && !secamKillActive && killLevelNtscPal == 9'h005)
        else $error("code 000 must kill ntsc and pal only");

    secam_kill_a: assert property (
        killSet(3'h1)
        |=> secamKillActive && killLevelSecam == 9'h032)
        else $error("code 001 secam kill level wrong");

    kill_six_a: assert property (
        killSet(3'h6)
        |=> killLevelNtscPal == 9'h140 && killLevelSecam == 9'h140)
        else $error("wrong kill levels for code 110");

    kill_rsvd_a: assert property (
        killSet(3'h7)
        |=> !colorKillActive && killLevelSecam == 9'h000)
        else $error("reserved kill code applied a kill");

    kill_gate_a: assert property (
        !colorKillEnable
        |=> !colorKillActive && killLevelNtscPal == 9'h000 && !secamKillActive)
        else $error("color kill applied while disabled");

    // the lock output follows the raw bit one edge late
    pal_switch_a: assert property (
        ##1 subcarrierPalSwitch == ($past(palSwitchRaw) ^ $past(st_r.palSwInv)))
        else $error("pal switch polarity wrong");

    // chroma and noise controls
    cti_enable_a: assert property (
        regWr(VDC_OFS_CHROMA)
        |=> chromaImproverEnable == $past(wrData[0]))
        else $error("improver enable not taken");

    blend_enable_a: assert property (
        regWr(VDC_OFS_CHROMA)
        |=> chromaBlendEnable == $past(wrData[1]))
        else $error("blend enable not taken");

    blend_level_a: assert property (
        regWr(VDC_OFS_CHROMA)
        |=> chromaBlendLevel == $past(wrData[3:2]))
        else $error("blend level not taken");

    dnr_enable_a: assert property (
        regWr(VDC_OFS_CHROMA)
        |=> noiseReductionEnable == $past(wrData[5]))
        else $error("noise reduction enable not taken");

    // a threshold holds once written until the next write to it
    edge_thr_a: assert property (
        regWr(VDC_OFS_EDGE_TH)
        |=> chromaEdgeThreshold == $past(wrData) ##1 $stable(chromaEdgeThreshold) || wrStb)
        else $error("edge threshold not taken");

    noise_thr_a: assert property (
        regWr(VDC_OFS_NOISE_TH)
        |=> noiseThreshold == $past(wrData))
        else $error("noise threshold not taken");

endmodule : vdc_config_regs
`default_nettype wire

// ### test/test_video_decoder_config_regs.sv
// self-checking bench for the video decoder config register bank
// acts as bus master on the two-wire port; sda is open drain with a pull-up
`timescale 1ns/10ps
`default_nettype none
module test_video_decoder_config_regs
    import vdc_pkg::*;
;
logic       sys_clk = 1'b0;
logic       rst = 1'b1;
logic       scl = 1'b1;
logic       sdaDrv = 1'b1;
logic [4:0] inputSelect = 5'h00;
logic       colorKillEnable = 1'b0;
logic       palSwitchRaw = 1'b0;
logic       sdaOe, pdn0, imp, bEn, dnr, kOn, sOn, psw;
logic [2:0] comb, pdn;
logic [8:0] lvlNp, lvlSc;
logic [1:0] bLvl;
logic [7:0] edgeTh, noiseTh, v;
wire        sdaIn = sdaDrv & ~sdaOe;
int         miscompares = 0;
int         check_count = 0;
int         cycles = 0;
int         used;
int         npLvl [8] = '{5, 15, 25, 40, 85, 160, 320, 0};
int         scLvl [8] = '{0, 50, 70, 80, 95, 150, 320, 0};

vdc_config_regs i_dut (.sys_clk, .rst, .scl, .sdaIn, .sdaOut(pdn0), .sdaOe, .inputSelect, .colorKillEnable,
    .palSwitchRaw, .palCombSel(comb), .selectorPowerdown(pdn), .colorKillActive(kOn), .secamKillActive(sOn),
    .killLevelNtscPal(lvlNp), .killLevelSecam(lvlSc), .subcarrierPalSwitch(psw), .chromaImproverEnable(imp),
    .chromaBlendEnable(bEn), .chromaBlendLevel(bLvl), .noiseReductionEnable(dnr),
    .chromaEdgeThreshold(edgeTh), .noiseThreshold(noiseTh));

always #5 sys_clk = ~sys_clk;

task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask : complete_run

// a whole run needs about 66000 cycles
always @(posedge sys_clk)
begin
    cycles++;
    if (cycles == 90000)
    begin
        miscompares++;
        complete_run();
    end
end

task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e)
    begin
        miscompares++;
        $display("BAD %s expected %h seen %h", nm, e, g);
    end
endtask : chk

task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
endtask : tick

// sda settles two cycles after scl falls so no edge is taken for a start or stop
task automatic bitx(input logic b, output logic r);
    sdaDrv = b;
    tick(10);
    scl = 1'b1;
    tick(10);
    r = sdaIn;
    scl = 1'b0;
    tick(2);
endtask : bitx

task automatic cond(input logic stp);
    sdaDrv = ~stp;
    tick(10);
    scl = 1'b1;
    tick(10);
    sdaDrv = stp;
    tick(10);
    if (!stp)
    begin
        scl = 1'b0;
        tick(10);
    end
endtask : cond

task automatic xfer(input logic [7:0] d, input logic ak, input logic ck, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
        bitx(d[i], q[i]);
    bitx(ak, a);
    if (ck)
        chk("ack", 9'h000, {8'h00, a});
endtask : xfer

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    cond(1'b0);
    xfer({VDC_DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
    xfer(a, 1'b1, 1'b1, q);
    xfer(d, 1'b1, 1'b1, q);
    cond(1'b1);
    tick(4);
endtask : wr

task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    cond(1'b0);
    xfer({VDC_DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
    xfer(a, 1'b1, 1'b1, q);
    cond(1'b0);
    xfer({VDC_DEV_ADDR, 1'b1}, 1'b1, 1'b1, q);
    xfer(8'hff, 1'b1, 1'b0, q);
    cond(1'b1);
    chk("readback", {1'b0, e}, {1'b0, q});
endtask : rdchk

initial
begin
    void'($urandom(69));
    tick(6);
    rst = 1'b0;
    tick(3);
    chk("edgeTh", 9'h008, {1'b0, edgeTh});
    chk("noiseTh", 9'h008, {1'b0, noiseTh});
    chk("sdaOut", 9'h000, {8'h00, pdn0});
    rdchk(8'h4e, 8'h08);
    rdchk(8'h50, 8'h08);
    rdchk(8'h60, 8'h00);
    // the last pass writes the unused code 00, which must leave 5-to-4 in place
    for (int c = 1; c <= 4; c++)
    begin
        wr(8'h39, 8'(c << 6));
        chk("comb", 9'(c == 4 ? 4 : 1 << (c - 1)), {6'h00, comb});
        rdchk(8'h39, 8'(c == 4 ? 8'hc0 : c << 6));
    end
    for (int i = 0; i < 16; i++)
    begin
        v = 8'(i) ^ (8'($urandom) & 8'h0e);
        inputSelect = 5'($urandom);
        wr(8'h3a, v);
        used = inputSelect < 8 ? 1 : inputSelect < 14 ? 3 : inputSelect < 16 ? 7 : 3;
        chk("pdn", 9'(v[0] ? ({v[1], v[2], v[3]} | 3'(~used)) : 0), {6'h00, pdn});
        rdchk(8'h3a, v);
    end
    for (int c = 0; c < 8; c++)
    begin
        wr(8'h3d, 8'(c << 4) | 8'h02);
        rdchk(8'h3d, 8'(c << 4) | 8'h02);
        for (int e = 0; e < 2; e++)
        begin
            colorKillEnable = e[0];
            tick(3);
            chk("kill", 9'(e == 1 && c != 7), {8'h00, kOn});
            chk("secam", 9'(e == 1 && c != 7 && c != 0), {8'h00, sOn});
            chk("lvlNp", 9'(e == 1 ? npLvl[c] : 0), lvlNp);
            chk("lvlSc", 9'(e == 1 ? scLvl[c] : 0), lvlSc);
        end
    end
    for (int k = 0; k < 4; k++)
    begin
        palSwitchRaw = k[1];
        wr(8'h41, {1'b0, k[0], 6'h01});
        chk("palSw", 9'(k[0] ^ k[1]), {8'h00, psw});
        rdchk(8'h41, {1'b0, k[0], 6'h01});
    end
    for (int i = 0; i < 4; i++)
    begin
        v = {2'b11, 1'($urandom), 1'b0, 2'(i), 2'($urandom)};
        wr(8'h4d, v);
        chk("chroma", {4'h0, v[5], v[3:0]}, {4'h0, dnr, bLvl, bEn, imp});
        rdchk(8'h4d, v);
        v = 8'($urandom);
        wr(i[0] ? 8'h50 : 8'h4e, v);
        chk("thr", {1'b0, v}, {1'b0, i[0] ? noiseTh : edgeTh});
        rdchk(i[0] ? 8'h50 : 8'h4e, v);
    end
    complete_run();
end
endmodule : test_video_decoder_config_regs
`default_nettype wire
